// ---- hdl/adcss_scan_seq.sv ----
// Scan sequencer of a 12-bit SAR converter with an APB register slave.
// Assumes trigA/trigB are one-cycle pulses on mclk and convDone is a
// one-cycle pulse from the analog core on mclk; extTrigN is asynchronous.
//
// Functional notes
// - Dual-trigger mode ignores channel select and converts only the dual channel on non-B scans.
// - First dual result goes to normal register, second to duplication register.
// - Scan-end interrupt on non-B scans if enabled; dual mode after second only.
// - Run set by group-A sync trigger, or by external pin when source is 1.
// - Single scan converts selected channels ascending once, then clears run.
// - Continuous scan repeats while run is 1; writing 0 stops at once.
// - Group scan runs A on A trigger, B on B trigger, each once ascending.
// - Mask 0000h in single mode converts the internal source once, then stops.
// - Run set by software write of 1, and by group-B trigger in group mode.
// - Run cleared by write 0, single scan end, and group A or B scan end.
// - With priority on, group-A trigger aborts a running group-B scan.
// - Priority mode: B trigger sets run; rescan restarts B from its first channel, repeat reruns B.
// - Low select bits 0..7 enable inputs 0..7; bits 15..8 read as 0.
// - Five-bit dual field picks one of inputs 0 to 31.
// - External pin high before enabling; falling edge starts, low 1.5 clocks.
// - Mode 00 single, 01 group, 10 continuous, 11 prohibited.
//
// The APB slave port was decided locally.
`include "adcss_consts.svh"
`default_nettype none
module adcss_scan_seq (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigA,
  input wire logic trigB,
  input wire logic extTrigN,
  input wire logic convDone,
  output adcss_pkg::adcss_conv_s conv,
  output logic convRun,
  output logic speedSel,
  output logic scanEndIrq,
  output logic groupBScanEndIrq
);
  typedef struct packed {
    adcss_pkg::adcss_ctrl_s ctrl;
    logic [7:0] chsel;
    adcss_pkg::adcss_prio_s prio;
    adcss_pkg::adcss_state_e state;
    logic [7:0] remMask;
    logic dualPend;
    logic intPend;
    logic scanB;
    logic secondTrig;
    logic bPend;
    adcss_pkg::adcss_conv_s conv;
    logic irqA;
    logic irqB;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adcss_top_s;

  adcss_top_s st;
  adcss_top_s next_st;
  logic extFall;
  logic found;
  logic [2:0] idx;
  logic wrAccess;
  logic swStart;
  logic stopWr;
  logic trigAEvt;
  logic trigBEvt;
  logic groupMode;

  adcss_pin_sync u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinN(extTrigN),
    .fall(extFall)
  );

  adcss_chan_pick u_chan_pick (
    .mask(st.remMask),
    .found(found),
    .idx(idx)
  );

  // Loads the channel walk for a new scan of group A or group B
  function automatic adcss_top_s begin_scan(input adcss_top_s s,
                                            input logic grpB);
    adcss_top_s r;
    r = s;
    r.ctrl.run = 1'b1;
    r.scanB = grpB;
    r.state = adcss_pkg::ST_ISSUE;
    r.dualPend = ~grpB & s.ctrl.dualSel;
    r.remMask = grpB ? s.prio.bMask :
                (s.ctrl.dualSel ? 8'h00 : s.chsel);
    r.intPend = ~grpB & ~s.ctrl.dualSel & (s.chsel == 8'h00) &
                (s.ctrl.mode == `ADCSS_MODE_SINGLE);
    return r;
  endfunction

  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [31:0] off);
    return a == off;
  endfunction

  assign groupMode = st.ctrl.mode == `ADCSS_MODE_GROUP;
  assign wrAccess = psel & penable & pwrite & st.pready;
  assign swStart = wrAccess & addr_is(paddr, `ADCSS_OFF_CTRL) &
                   pwdata[`ADCSS_RUN_BIT] & ~st.ctrl.run;
  assign stopWr = wrAccess & addr_is(paddr, `ADCSS_OFF_CTRL) &
                  ~pwdata[`ADCSS_RUN_BIT];
  assign trigAEvt = st.ctrl.trgEnable &
                    ((~st.ctrl.trgSource & trigA) |
                     (st.ctrl.trgSource & extFall));
  assign trigBEvt = st.ctrl.trgEnable & groupMode & trigB;

  always_comb begin
    next_st = st;
    next_st.conv.start = 1'b0;
    next_st.irqA = 1'b0;
    next_st.irqB = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // Setup phase: latch read data so the access phase answers from flops
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      if (addr_is(paddr, `ADCSS_OFF_CTRL)) begin
        next_st.prdata = {16'h0000, st.ctrl};
      end else if (addr_is(paddr, `ADCSS_OFF_CHSEL)) begin
        next_st.prdata = {24'h00_0000, st.chsel};
      end else if (addr_is(paddr, `ADCSS_OFF_PRIO)) begin
        next_st.prdata = {16'h0000, st.prio.bMask, 5'h00,
                          st.prio.repeatB, st.prio.rescan, st.prio.priority_mode_enable};
      end else if (addr_is(paddr, `ADCSS_OFF_STAT)) begin
        next_st.prdata = {19'h0_0000, st.conv.chan, 2'h0, st.bPend,
                          st.secondTrig, st.scanB, st.state};
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    if (wrAccess) begin
      if (addr_is(paddr, `ADCSS_OFF_CTRL)) begin
        next_st.ctrl = adcss_pkg::adcss_ctrl_s'(pwdata[15:0] &
                                                `ADCSS_CTRL_RSV_MASK);
        next_st.ctrl.run = st.ctrl.run;
        // Leaving dual mode drops a half-done trigger pair
        next_st.secondTrig = st.secondTrig & next_st.ctrl.dualSel;
      end else if (addr_is(paddr, `ADCSS_OFF_CHSEL)) begin
        next_st.chsel = pwdata[7:0];
      end else if (addr_is(paddr, `ADCSS_OFF_PRIO)) begin
        next_st.prio.priority_mode_enable = pwdata[`ADCSS_PRIO_PGS_BIT];
        next_st.prio.rescan = pwdata[`ADCSS_PRIO_RESCAN_BIT];
        next_st.prio.repeatB = pwdata[`ADCSS_PRIO_REPEAT_BIT];
        next_st.prio.bMask = pwdata[`ADCSS_PRIO_BMASK_LSB +: 8];
      end
    end

    if (stopWr) begin
      next_st.ctrl.run = 1'b0;
      next_st.state = adcss_pkg::ST_IDLE;
      next_st.bPend = 1'b0;
    end else begin
      case (st.state)
        adcss_pkg::ST_ISSUE: begin
          next_st.state = adcss_pkg::ST_WAIT;
          next_st.conv.start = 1'b1;
          next_st.conv.groupB = st.scanB;
          next_st.conv.dup = st.secondTrig;
          next_st.conv.internal = 1'b0;
          if (st.dualPend) begin
            next_st.dualPend = 1'b0;
            next_st.conv.chan = st.ctrl.dualPick;
          end else if (found) begin
            next_st.remMask[idx] = 1'b0;
            next_st.conv.chan = {2'h0, idx};
          end else if (st.intPend) begin
            next_st.intPend = 1'b0;
            next_st.conv.internal = 1'b1;
            next_st.conv.chan = 5'h00;
          end else begin
            next_st.conv.start = 1'b0;
            next_st.state = adcss_pkg::ST_IDLE;
            next_st.ctrl.run = 1'b0;
            if (st.scanB) begin
              next_st.irqB = st.ctrl.gbie;
              if (st.prio.priority_mode_enable && st.prio.repeatB) begin
                next_st = begin_scan(next_st, 1'b1);
              end
            end else if (st.ctrl.dualSel && !st.secondTrig) begin
              next_st.secondTrig = 1'b1;
            end else begin
              next_st.secondTrig = 1'b0;
              next_st.irqA = st.ctrl.scan_end_irq_enable;
              if (st.ctrl.mode == `ADCSS_MODE_CONT) begin
                next_st = begin_scan(next_st, 1'b0);
              end
            end
          end
        end
        adcss_pkg::ST_WAIT: begin
          if (convDone) begin
            next_st.state = adcss_pkg::ST_ISSUE;
          end
        end
        default: begin
        end
      endcase

      // Triggers are only taken while idle or for group-A preemption
      if (next_st.state == adcss_pkg::ST_IDLE) begin
        if (swStart || trigAEvt) begin
          next_st = begin_scan(next_st, 1'b0);
        end else if (trigBEvt) begin
          next_st = begin_scan(next_st, 1'b1);
        end else if (groupMode && st.prio.priority_mode_enable && st.prio.rescan &&
                     st.bPend) begin
          next_st.bPend = 1'b0;
          next_st = begin_scan(next_st, 1'b1);
        end
      end else if (st.scanB && groupMode && st.prio.priority_mode_enable && trigAEvt) begin
        next_st.bPend = st.prio.rescan;
        next_st = begin_scan(next_st, 1'b0);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= adcss_pkg::adcss_ctrl_s'(`ADCSS_CTRL_RESET);
      st.chsel <= `ADCSS_CHSEL_RESET;
      st.state <= adcss_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign conv = st.conv;
  assign convRun = st.ctrl.run;
  assign speedSel = st.ctrl.speedSel;
  assign scanEndIrq = st.irqA;
  assign groupBScanEndIrq = st.irqB;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_dual_channel: assert property (
    conv.start && !conv.groupB && st.ctrl.dualSel |-> conv.chan ==
    st.ctrl.dualPick && st.remMask == 8'h00)
    else $error("dual mode converted a channel other than the pick");

  chk_dup_second: assert property (
    st.secondTrig && st.state == adcss_pkg::ST_ISSUE && st.dualPend
    |=> conv.start && conv.dup)
    else $error("second dual conversion not marked for duplication");

  chk_irq_dual_first: assert property (
    $rose(st.secondTrig) |-> !scanEndIrq && !convRun)
    else $error("scan end raised after first dual conversion");

  chk_irq_enable: assert property (
    scanEndIrq |-> $past(st.ctrl.scan_end_irq_enable) && !$past(st.scanB))
    else $error("scan end pulse without enable or from group B");

  chk_ext_trigger: assert property (
    st.state == adcss_pkg::ST_IDLE && !wrAccess && st.ctrl.trgEnable &&
    st.ctrl.trgSource && extFall |=> convRun ##1 conv.start)
    else $error("external falling edge did not start a scan");

  chk_stop_write: assert property (
    stopWr |=> !convRun && st.state == adcss_pkg::ST_IDLE)
    else $error("writing run 0 did not stop conversion");

  chk_single_end: assert property (
    st.state == adcss_pkg::ST_ISSUE && !found && !st.dualPend &&
    !st.intPend && !st.scanB && !stopWr && !trigAEvt &&
    st.ctrl.mode == `ADCSS_MODE_SINGLE |=> !convRun)
    else $error("single scan end left run set");

  chk_ascending: assert property (
    conv.start && !conv.internal && !conv.groupB && !st.ctrl.dualSel
    |-> ((st.remMask << (3'h7 - conv.chan[2:0])) & 8'h7F) == 8'h00)
    else $error("channel walk not in ascending order");

  chk_preempt: assert property (
    st.state != adcss_pkg::ST_IDLE && st.scanB && groupMode &&
    st.prio.priority_mode_enable && trigAEvt && !stopWr |=> !st.scanB && convRun)
    else $error("group A trigger failed to preempt group B");

  chk_bus_answer: assert property (
    psel && !penable |=> pready [*1] ##1 !pready)
    else $error("APB answer not exactly one access cycle");
endmodule
`default_nettype wire

// ---- include/adcss_consts.svh ----
// Register offsets, field positions and reset values of the scan sequencer.
// Assumes a 32-bit APB byte address; each register takes one aligned word.
`ifndef ADCSS_CONSTS_SVH
`define ADCSS_CONSTS_SVH

`define ADCSS_OFF_CTRL 32'h0008_9000
`define ADCSS_OFF_CHSEL 32'h0008_9004
`define ADCSS_OFF_PRIO 32'h0008_9010
`define ADCSS_OFF_STAT 32'h0008_9014

`define ADCSS_CTRL_RESET 16'h0000
`define ADCSS_CHSEL_RESET 8'h00
`define ADCSS_CTRL_RSV_MASK 16'hF7DF
`define ADCSS_RUN_BIT 15

`define ADCSS_MODE_SINGLE 2'h0
`define ADCSS_MODE_GROUP 2'h1
`define ADCSS_MODE_CONT 2'h2

`define ADCSS_PRIO_PGS_BIT 0
`define ADCSS_PRIO_RESCAN_BIT 1
`define ADCSS_PRIO_REPEAT_BIT 2
`define ADCSS_PRIO_BMASK_LSB 8

`endif

// ---- include/adcss_pkg.sv ----
// Types shared by the scan sequencer modules.
// Assumes adcss_consts.svh holds the numeric constants.
`default_nettype none
package adcss_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ISSUE = 3'h2,
    ST_WAIT = 3'h4
  } adcss_state_e;

  // Field order follows the control register bit layout, bit 15 first
  typedef struct packed {
    logic run;
    logic [1:0] mode;
    logic scan_end_irq_enable;
    logic rsv11;
    logic speedSel;
    logic trgEnable;
    logic trgSource;
    logic dualSel;
    logic gbie;
    logic rsv5;
    logic [4:0] dualPick;
  } adcss_ctrl_s;

  typedef struct packed {
    logic start;
    logic [4:0] chan;
    logic dup;
    logic internal;
    logic groupB;
  } adcss_conv_s;

  typedef struct packed {
    logic priority_mode_enable;
    logic rescan;
    logic repeatB;
    logic [7:0] bMask;
  } adcss_prio_s;

endpackage
`default_nettype wire

// ---- hdl/adcss_pin_sync.sv ----
// Two-flop synchroniser for the external trigger pin with falling-edge pulse.
// Assumes the pin is asynchronous to mclk.
`default_nettype none
module adcss_pin_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pinN,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } adcss_sync_s;

  adcss_sync_s st;
  adcss_sync_s next_st;

  always_comb begin
    next_st.meta = pinN;
    next_st.sync = st.meta;
    next_st.last = st.sync;
  end

  // Pin idles high, so reset to 1 keeps a released pin from looking like an edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  assign fall = st.last & ~st.sync;
endmodule
`default_nettype wire

// ---- hdl/adcss_chan_pick.sv ----
// Finds the lowest set bit of a channel mask.
// Purely combinational; used by the sequencer to walk channels upward.
`default_nettype none
module adcss_chan_pick (
  input wire logic [7:0] mask,
  output logic found,
  output logic [2:0] idx
);
  always_comb begin
    found = 1'b0;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (mask[i]) begin
        found = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/adcss_core_model.sv ----
// Behavioural analog core on the far side of the scan sequencer.
// Assumes conv.start is a one-cycle pulse; answers after lat cycles.
`default_nettype none
module adcss_core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire adcss_pkg::adcss_conv_s conv,
  input wire logic convRun,
  input wire logic [3:0] lat,
  output logic convDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      convDone <= 1'b0;
    end else begin
      convDone <= 1'b0;
      if (conv.start) begin
        cnt <= lat;
      end else if (!convRun) begin
        // A stopped scan abandons the pending conversion
        cnt <= 0;
      end else if (cnt == 1) begin
        convDone <= 1'b1;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_adc_scan_sequencer.sv ----
// Self-checking bench: APB master, trigger sources and a queue model.
// Assumes the analog core model answers every conversion start.
`include "adcss_consts.svh"
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  error_cnt++; $display("wrong value t=%0t got=%h exp=%h", \
  $time, a, b); end end
module tb_adc_scan_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r, s;
  logic trigA, trigB, extTrigN, convDone, convRun, speedSel;
  logic scanEndIrq, groupBScanEndIrq, e;
  logic [3:0] lat;
  logic [7:0] m;
  logic [4:0] pick;
  adcss_pkg::adcss_conv_s conv;
  logic [7:0] expQ[$];
  int error_cnt, total_checks, irqA, irqB;
  adcss_scan_seq dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigA(trigA),
    .trigB(trigB), .extTrigN(extTrigN), .convDone(convDone), .conv(conv),
    .convRun(convRun), .speedSel(speedSel), .scanEndIrq(scanEndIrq),
    .groupBScanEndIrq(groupBScanEndIrq));
  adcss_core_model core (.mclk(mclk), .rst_n(rst_n), .conv(conv),
    .convRun(convRun), .lat(lat), .convDone(convDone));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] ex(input int ch, dup, in, gb);
    return {ch[4:0], dup[0], in[0], gb[0]};
  endfunction
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge mclk);
    if (b) trigB <= 1'b1; else trigA <= 1'b1;
    @(posedge mclk);
    trigA <= 1'b0;
    trigB <= 1'b0;
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    do begin @(posedge mclk); #1; n++; end
    while ((expQ.size() != 0 || convRun !== 1'b0) && n < 3000);
    `CHK(n < 3000, 1'b1)
    repeat (2) @(posedge mclk);
  endtask
  task automatic scan(input logic [31:0] c, input logic [7:0] mk);
    for (int i = 0; i < 8; i++) if (mk[i]) expQ.push_back(ex(i, 0, 0, 0));
    if (mk == 8'h00) expQ.push_back(ex(0, 0, 1, 0));
    apb(1, `ADCSS_OFF_CHSEL, {24'h0, mk});
    apb(1, `ADCSS_OFF_CTRL, c);
    irqA = 0;
    apb(1, `ADCSS_OFF_CTRL, c | 32'h8000);
    waitIdle();
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (conv.start === 1'b1) begin
      if (expQ.size() == 0) `CHK(conv[7:0], 8'hFF)
      else `CHK(conv[7:0], expQ.pop_front())
    end
    if (scanEndIrq === 1'b1) irqA++;
    if (groupBScanEndIrq === 1'b1) irqB++;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    results();
  end
  initial begin
    {rst_n, psel, penable, pwrite, trigA, trigB} = '0;
    paddr = '0; pwdata = '0; extTrigN = 1'b1; lat = 4'h3;
    s = 32'hE47216E0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    apb(0, `ADCSS_OFF_CTRL, 0); `CHK(r, 32'h0)
    apb(1, `ADCSS_OFF_CHSEL, 32'hFFFF);
    apb(0, `ADCSS_OFF_CHSEL, 0); `CHK(r, 32'hFF)
    apb(1, `ADCSS_OFF_CTRL, 32'h0C20);
    apb(0, `ADCSS_OFF_CTRL, 0); `CHK(r, 32'h0400)
    `CHK(speedSel, 1'b1)
    apb(0, 32'h0008_9020, 0); `CHK({e, r}, 33'h100000000)
    for (int k = 0; k < 4; k++) begin
      s = lfsr(s); lat <= 4'h1 + s[10:8];
      m = (k == 0) ? 8'hFF : s[7:0];
      scan(32'h1000, (k == 3) ? 8'h00 : m);
      `CHK(irqA, 1)
    end
    lat <= 4'h8;
    for (int k = 0; k < 5; k++) expQ.push_back(ex(1 + k % 2, 0, 0, 0));
    apb(1, `ADCSS_OFF_CHSEL, 32'h06);
    apb(1, `ADCSS_OFF_CTRL, 32'h4000);
    apb(1, `ADCSS_OFF_CTRL, 32'hC000);
    while (expQ.size() != 0) @(posedge mclk);
    apb(1, `ADCSS_OFF_CTRL, 32'h4000);
    repeat (30) @(posedge mclk);
    `CHK(convRun, 1'b0)
    lat <= 4'h2;
    apb(1, `ADCSS_OFF_CHSEL, 32'h10);
    apb(1, `ADCSS_OFF_CTRL, 32'h1200);
    pulse(1); repeat (10) @(posedge mclk);
    `CHK(convRun, 1'b0)
    expQ.push_back(ex(4, 0, 0, 0));
    pulse(0); waitIdle();
    apb(1, `ADCSS_OFF_CTRL, 32'h1300);
    pulse(0); repeat (10) @(posedge mclk);
    `CHK(convRun, 1'b0)
    expQ.push_back(ex(4, 0, 0, 0));
    @(posedge mclk) extTrigN <= 1'b0;
    repeat (2) @(posedge mclk);
    extTrigN <= 1'b1;
    waitIdle();
    s = lfsr(s); pick = s[4:0];
    apb(1, `ADCSS_OFF_CTRL, 32'h0);
    apb(1, `ADCSS_OFF_CHSEL, 32'hFF);
    apb(1, `ADCSS_OFF_CTRL, {19'h0, 13'h1280 | pick});
    irqA = 0;
    for (int k = 0; k < 2; k++) begin
      expQ.push_back(ex(pick, k, 0, 0));
      pulse(0); waitIdle();
      `CHK(irqA, k)
    end
    apb(1, `ADCSS_OFF_CTRL, 32'h0);
    apb(1, `ADCSS_OFF_CHSEL, 32'h05);
    apb(1, `ADCSS_OFF_PRIO, 32'h3000);
    apb(1, `ADCSS_OFF_CTRL, 32'h3240);
    {irqA, irqB} = '0;
    expQ = {ex(0, 0, 0, 0), ex(2, 0, 0, 0)};
    pulse(0); pulse(0); waitIdle();
    expQ = {ex(4, 0, 0, 1), ex(5, 0, 0, 1)};
    pulse(1); waitIdle();
    `CHK({irqA, irqB}, {32'd1, 32'd1})
    lat <= 4'h8;
    apb(1, `ADCSS_OFF_PRIO, 32'h3003);
    expQ = {ex(4, 0, 0, 1)};
    pulse(1);
    while (expQ.size() != 0) @(posedge mclk);
    expQ = {ex(0, 0, 0, 0), ex(2, 0, 0, 0), ex(4, 0, 0, 1), ex(5, 0, 0, 1)};
    pulse(0); waitIdle();
    results();
  end
endmodule
`default_nettype wire
